// file: hdl/seecs_cfg.svh
// Constants of the serial EEPROM command and status block
`ifndef SEECS_CFG_SVH
`define SEECS_CFG_SVH
`define SEECS_OP_HI 4'h0
`define SEECS_OP_SET 3'h6
`define SEECS_OP_CLR 3'h4
`define SEECS_OP_STATUS_READ_CMD 3'h5
`define SEECS_OP_STATUS_WRITE_CMD 3'h1
`define SEECS_OP_READ 3'h3
`define SEECS_OP_WRITE 3'h2
`define SEECS_BP_NONE 2'h0
`define SEECS_BP_QTR 2'h1
`define SEECS_BP_HALF 2'h2
`define SEECS_BP_ALL 2'h3
`define SEECS_RFU_BUSY 4'hf
`define SEECS_RFU_IDLE 4'h0
`define SEECS_MEM_INIT 8'hff
`define SEECS_TWC_US 5000
`define SEECS_CLK_MHZ 50
`define SEECS_WC_CYCLES (`SEECS_TWC_US * `SEECS_CLK_MHZ)
`endif

// file: hdl/seecs_pkg.sv
// Types of the serial EEPROM command and status block
package seecs_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_OPCODE, ST_DONE, ST_IGNORE, ST_STAT,
        ST_STATUS_WRITE_CMD, ST_RD_ADDR, ST_RD_DATA, ST_WR_ADDR, ST_WR_DATA
    } seecs_state_e;
    typedef enum logic [2:0] {
        C_NONE, C_SET, C_CLR, C_STATUS_WRITE_CMD, C_WR
    } seecs_cmd_e;
endpackage

// file: hdl/seecs_top.sv
// SPI client command decoder, status register and array read of an EEPROM
`timescale 1ns/1ps
`default_nettype none
`include "seecs_cfg.svh"
module seecs_top #(
    parameter int ADDR_W = 9,
    parameter int WC_CYCLES = `SEECS_WC_CYCLES
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // SPI pins
    input wire logic i_cs_b,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_wp_b,
    output logic o_so,
    output logic o_so_oe,
    // Nonvolatile protect cells
    input wire logic [1:0] i_nv_protect,
    output logic [1:0] o_nv_protect,
    // Array write stream toward the programmer
    output logic o_wr_valid,
    output logic [ADDR_W+7:0] o_wr_data,
    input wire logic i_wr_ready,
    output logic o_wr_overrun,
    // Status mirror
    output logic [7:0] o_status
);
    localparam int WC_W = $clog2(WC_CYCLES + 1);
    localparam int DEPTH = 1 << ADDR_W;

    logic [3:0] sync1;
    logic [3:0] sync2;
    logic cs_q;
    logic sck_q;
    logic cs_s;
    logic sck_s;
    logic si_s;
    logic wp_s;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    seecs_pkg::seecs_state_e st;
    seecs_pkg::seecs_cmd_e cmd;
    logic [2:0] cnt;
    logic [2:0] ocnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] rx_byte;
    logic a8;
    logic [8:0] full_addr;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] waddr;
    logic wr_any;
    logic [1:0] newbp;
    logic push;
    logic [ADDR_W+7:0] push_data;
    logic write_enable_latch;
    logic busy;
    logic nv_ok;
    logic [WC_W-1:0] wc;
    logic [7:0] next_status;
    logic [7:0] mem [0:DEPTH-1];
    logic [ADDR_W+7:0] spare;
    logic spare_v;
    logic full;
    logic pop;

    function automatic logic prot_hit(input logic [1:0] bp,
                                      input logic [ADDR_W-1:0] a);
        case (bp)
            `SEECS_BP_QTR: return a[ADDR_W-1] & a[ADDR_W-2];
            `SEECS_BP_HALF: return a[ADDR_W-1];
            `SEECS_BP_ALL: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Pins come from the host's domain; two stages before any use
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            // Idle pin levels, so that no false clock edge follows reset
            sync1 <= 4'h9;
            sync2 <= 4'h9;
            cs_q <= 1'b1;
            sck_q <= 1'b0;
        end else begin
            sync1 <= {i_wp_b, i_si, i_sck, i_cs_b};
            sync2 <= sync1;
            cs_q <= sync2[0];
            sck_q <= sync2[1];
        end
    end

    assign cs_s = sync2[0];
    assign sck_s = sync2[1];
    assign si_s = sync2[2];
    assign wp_s = sync2[3];
    assign cs_fall = cs_q & ~cs_s;
    assign cs_rise = cs_s & ~cs_q;
    assign sck_rise = sck_s & ~sck_q;
    assign sck_fall = sck_q & ~sck_s;
    assign rx_byte = {sh[6:0], si_s};
    assign full_addr = {a8, rx_byte};
    assign full = o_wr_valid & spare_v;
    assign pop = o_wr_valid & i_wr_ready;

    always_comb begin
        next_status = {busy ? `SEECS_RFU_BUSY : `SEECS_RFU_IDLE,
                       o_nv_protect, write_enable_latch, busy};
    end

    // Serial engine: bytes in on rising clock, bits out on falling
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st <= seecs_pkg::ST_IDLE;
            cmd <= seecs_pkg::C_NONE;
            cnt <= 3'h0;
            ocnt <= 3'h0;
            sh <= 8'h00;
            tx <= 8'h00;
            a8 <= 1'b0;
            addr <= '0;
            waddr <= '0;
            wr_any <= 1'b0;
            newbp <= 2'h0;
            push <= 1'b0;
            push_data <= '0;
            o_so <= 1'b0;
            o_so_oe <= 1'b0;
        end else begin
            push <= 1'b0;
            if (cs_s) begin
                st <= seecs_pkg::ST_IDLE;
                o_so_oe <= 1'b0;
                cnt <= 3'h0;
            end else if (cs_fall) begin
                st <= seecs_pkg::ST_OPCODE;
                cmd <= seecs_pkg::C_NONE;
                cnt <= 3'h0;
            end else if (sck_rise && st != seecs_pkg::ST_IGNORE) begin
                cnt <= cnt + 3'h1;
                sh <= rx_byte;
                if (cnt == 3'h7) begin
                    case (st)
                        seecs_pkg::ST_OPCODE: begin
                            if (rx_byte[7:4] != `SEECS_OP_HI || !nv_ok) begin
                                st <= seecs_pkg::ST_IGNORE;
                            end else if (busy &&
                                rx_byte[2:0] != `SEECS_OP_STATUS_READ_CMD) begin
                                st <= seecs_pkg::ST_IGNORE;
                            end else begin
                                case (rx_byte[2:0])
                                    `SEECS_OP_SET: begin
                                        cmd <= seecs_pkg::C_SET;
                                        st <= seecs_pkg::ST_DONE;
                                    end
                                    `SEECS_OP_CLR: begin
                                        cmd <= seecs_pkg::C_CLR;
                                        st <= seecs_pkg::ST_DONE;
                                    end
                                    `SEECS_OP_STATUS_READ_CMD: begin
                                        st <= seecs_pkg::ST_STAT;
                                        tx <= next_status;
                                        ocnt <= 3'h0;
                                    end
                                    `SEECS_OP_STATUS_WRITE_CMD: begin
                                        cmd <= seecs_pkg::C_STATUS_WRITE_CMD;
                                        st <= seecs_pkg::ST_STATUS_WRITE_CMD;
                                    end
                                    `SEECS_OP_READ: begin
                                        a8 <= rx_byte[3];
                                        st <= seecs_pkg::ST_RD_ADDR;
                                    end
                                    `SEECS_OP_WRITE: begin
                                        a8 <= rx_byte[3];
                                        wr_any <= 1'b0;
                                        cmd <= seecs_pkg::C_WR;
                                        st <= (write_enable_latch && wp_s) ?
                                            seecs_pkg::ST_WR_ADDR :
                                            seecs_pkg::ST_IGNORE;
                                    end
                                    default: st <= seecs_pkg::ST_IGNORE;
                                endcase
                            end
                        end
                        seecs_pkg::ST_STATUS_WRITE_CMD: begin
                            newbp <= rx_byte[3:2];
                            st <= seecs_pkg::ST_DONE;
                        end
                        seecs_pkg::ST_RD_ADDR: begin
                            tx <= mem[full_addr[ADDR_W-1:0]];
                            addr <= full_addr[ADDR_W-1:0] + 1'b1;
                            ocnt <= 3'h0;
                            st <= seecs_pkg::ST_RD_DATA;
                        end
                        seecs_pkg::ST_WR_ADDR: begin
                            waddr <= full_addr[ADDR_W-1:0];
                            st <= seecs_pkg::ST_WR_DATA;
                        end
                        seecs_pkg::ST_WR_DATA: begin
                            wr_any <= 1'b1;
                            waddr[2:0] <= waddr[2:0] + 3'h1;
                            push <= ~prot_hit(o_nv_protect, waddr);
                            push_data <= {waddr, rx_byte};
                        end
                        seecs_pkg::ST_DONE: st <= seecs_pkg::ST_IGNORE;
                        default: ;
                    endcase
                end
            end else if (sck_fall && (st == seecs_pkg::ST_STAT ||
                                      st == seecs_pkg::ST_RD_DATA)) begin
                o_so_oe <= 1'b1;
                o_so <= tx[7];
                tx <= {tx[6:0], 1'b0};
                ocnt <= ocnt + 3'h1;
                if (ocnt == 3'h7) begin
                    if (st == seecs_pkg::ST_STAT) begin
                        tx <= next_status;
                    end else begin
                        tx <= mem[addr];
                        addr <= addr + 1'b1;
                    end
                end
            end
        end
    end

    // Latch, protect bits and the self-timed cycle
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            write_enable_latch <= 1'b0;
            busy <= 1'b0;
            wc <= '0;
            nv_ok <= 1'b0;
            o_nv_protect <= `SEECS_BP_NONE;
        end else begin
            // Cells are reloaded after reset, so reset never erases them
            if (!nv_ok) begin
                o_nv_protect <= i_nv_protect;
                nv_ok <= 1'b1;
            end
            if (busy) begin
                if (wc == WC_W'(WC_CYCLES - 1)) begin
                    busy <= 1'b0;
                    write_enable_latch <= 1'b0;
                end else begin
                    wc <= wc + 1'b1;
                end
            end else if (cs_rise && cnt == 3'h0) begin
                case (cmd)
                    seecs_pkg::C_SET: begin
                        if (st == seecs_pkg::ST_DONE) write_enable_latch <= 1'b1;
                    end
                    seecs_pkg::C_CLR: begin
                        if (st == seecs_pkg::ST_DONE) write_enable_latch <= 1'b0;
                    end
                    seecs_pkg::C_STATUS_WRITE_CMD: begin
                        if (st == seecs_pkg::ST_DONE && write_enable_latch && wp_s) begin
                            o_nv_protect <= newbp;
                            busy <= 1'b1;
                            wc <= '0;
                        end
                    end
                    seecs_pkg::C_WR: begin
                        if (st == seecs_pkg::ST_WR_DATA && wr_any) begin
                            busy <= 1'b1;
                            wc <= '0;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_status <= 8'h00;
        end else begin
            o_status <= next_status;
        end
    end

    // Two-entry write buffer; the link cannot pause, so a byte met by a
    // full buffer is dropped and flagged until the next select
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wr_valid <= 1'b0;
            o_wr_data <= '0;
            spare <= '0;
            spare_v <= 1'b0;
            o_wr_overrun <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= `SEECS_MEM_INIT;
            end
        end else begin
            if (pop) begin
                mem[o_wr_data[ADDR_W+7:8]] <= o_wr_data[7:0];
            end
            if (pop || !o_wr_valid) begin
                if (spare_v) begin
                    o_wr_data <= spare;
                    o_wr_valid <= 1'b1;
                    spare <= push_data;
                    spare_v <= push;
                end else begin
                    o_wr_data <= push_data;
                    o_wr_valid <= push;
                end
            end else if (push && !spare_v) begin
                spare <= push_data;
                spare_v <= 1'b1;
            end
            if (cs_fall) begin
                o_wr_overrun <= 1'b0;
            end
            if (push && full && !pop) begin
                o_wr_overrun <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    a_so_desel: assert property (cs_s |=> !o_so_oe)
        else $error("output driven while deselected");
    a_ignore_quiet: assert property (st == seecs_pkg::ST_IGNORE |->
        !o_so_oe) else $error("output driven after bad opcode");
    a_busy_hold: assert property ($rose(busy) |-> busy[*8])
        else $error("write cycle ended too early");
    a_busy_wel: assert property ($fell(busy) |-> !write_enable_latch)
        else $error("latch still set after write cycle");
    a_status_write_cmd_gate: assert property ((cs_rise && cnt == 3'h0 && !busy &&
        cmd == seecs_pkg::C_STATUS_WRITE_CMD && st == seecs_pkg::ST_DONE && !write_enable_latch)
        |=> !busy && $stable(o_nv_protect))
        else $error("status write acted without latch");
    a_set_wel: assert property ((cs_rise && cnt == 3'h0 && !busy &&
        cmd == seecs_pkg::C_SET && st == seecs_pkg::ST_DONE) |=> write_enable_latch)
        else $error("set opcode did not set latch");
    a_clr_wel: assert property ((cs_rise && cnt == 3'h0 && !busy &&
        cmd == seecs_pkg::C_CLR && st == seecs_pkg::ST_DONE) |=> !write_enable_latch)
        else $error("clear opcode did not clear latch");
    a_prot_src: assert property (($past(nv_ok) &&
        $changed(o_nv_protect)) |-> $past(cs_rise) &&
        $past(cmd == seecs_pkg::C_STATUS_WRITE_CMD)) else $error("protect bits moved");
    a_rfu_busy: assert property (o_status[0] |->
        o_status[7:4] == `SEECS_RFU_BUSY) else $error("reserved bits wrong");
    a_no_prot: assert property (push |->
        !prot_hit(o_nv_protect, push_data[ADDR_W+7:8]))
        else $error("protected address passed on");

    c_set: cover property (cs_rise && cmd == seecs_pkg::C_SET &&
        st == seecs_pkg::ST_DONE);
    c_cycle: cover property ($rose(busy));
    c_read: cover property (st == seecs_pkg::ST_RD_DATA && sck_fall &&
        ocnt == 3'h7);
    c_full: cover property (push && full);
endmodule
`default_nettype wire

// file: sim/seecs_host.sv
// SPI host model driving the client pins of the EEPROM block in mode 0
`timescale 1ns/1ps
`default_nettype none
module seecs_host (
    // Clock
    input wire logic i_clock,
    // Client pins
    output logic o_cs_b,
    output logic o_sck,
    output logic o_si,
    output logic o_wp_b,
    input wire logic i_so,
    input wire logic i_so_oe
);
    logic so_last;
    logic so_line;

    initial begin
        o_cs_b = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        o_wp_b = 1'b1;
        so_last = 1'b0;
    end

    // No pull on the data line: a released line shows the opposite level
    always @(posedge i_clock) begin
        if (i_so_oe === 1'b1) begin
            so_last <= i_so;
        end
    end
    assign so_line = (i_so_oe === 1'b1) ? i_so : ~so_last;

    task automatic half();
        repeat (4) @(posedge i_clock);
        #1;
    endtask

    task automatic wp(input logic v);
        o_wp_b = v;
    endtask

    // One frame of nbits bits; a short count leaves a byte unfinished
    task automatic frame(input logic [47:0] tx, input int nbits,
                         output logic [47:0] rx);
        rx = '0;
        o_cs_b = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            o_si = tx[i];
            half();
            o_sck = 1'b1;
            rx = {rx[46:0], so_line};
            half();
            o_sck = 1'b0;
        end
        half();
        o_cs_b = 1'b1;
        o_si = ~o_si;
        repeat (3) half();
    endtask
endmodule
`default_nettype wire

// file: sim/spi_eeprom_command_status_tb.sv
// Self-checking bench of the EEPROM command and status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
$display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module spi_eeprom_command_status_tb;
    localparam int WC = 600;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cs_b, sck, si, wp_b, so, so_oe, wr_valid, wr_ready, overrun;
    logic [1:0] nv_in = 2'h2;
    logic [1:0] nv_out;
    logic [16:0] wr_data;
    logic [7:0] status;
    logic [16:0] q[$];
    logic oe_hit = 1'b0;
    logic [47:0] rx;
    int checks = 0;
    int mismatches = 0;

    always #10 clk = ~clk;

    seecs_top #(.ADDR_W(9), .WC_CYCLES(WC)) dut_u (
        .i_clock(clk), .i_rst_b(rst_b), .i_cs_b(cs_b), .i_sck(sck),
        .i_si(si), .i_wp_b(wp_b), .o_so(so), .o_so_oe(so_oe),
        .i_nv_protect(nv_in), .o_nv_protect(nv_out),
        .o_wr_valid(wr_valid), .o_wr_data(wr_data),
        .i_wr_ready(wr_ready), .o_wr_overrun(overrun), .o_status(status)
    );

    seecs_host host_u (
        .i_clock(clk), .o_cs_b(cs_b), .o_sck(sck), .o_si(si),
        .o_wp_b(wp_b), .i_so(so), .i_so_oe(so_oe)
    );

    always @(posedge clk) begin
        if (so_oe === 1'b1) begin
            oe_hit = 1'b1;
        end
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            q.push_back(wr_data);
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic status_read_cmd(input logic [7:0] exp);
        host_u.frame(48'h0500, 16, rx);
        `CHK(rx[7:0], exp)
    endtask

    task automatic cmd(input logic [7:0] op);
        host_u.frame({40'h0, op}, 8, rx);
    endtask

    task automatic settle();
        repeat (WC + 50) @(posedge clk);
        #1;
    endtask

    initial begin
        #1000000;
        mismatches++;
        end_sim();
    end

    initial begin
        wr_ready = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        status_read_cmd(8'h08);
        `CHK(nv_out, 2'h2)
        `CHK(status, 8'h08)
        $display("test power-up done");

        // Both values of the don't-care bit; clear works with guard low
        for (int x = 0; x < 16; x += 8) begin
            cmd(8'h06 | x[7:0]);
            status_read_cmd(8'h0a);
            host_u.wp(1'b0);
            cmd(8'h04 | x[7:0]);
            host_u.wp(1'b1);
            status_read_cmd(8'h08);
        end
        // Set opcode followed by a partial byte must be cancelled
        host_u.frame(48'h0300, 15, rx);
        status_read_cmd(8'h08);
        $display("test latch done");

        for (int k = 0; k < 2; k++) begin
            oe_hit = 1'b0;
            host_u.frame(k == 0 ? 48'h10ff : 48'h07ff, 16, rx);
            `CHK(oe_hit, 1'b0)
        end
        host_u.frame(48'h01fc, 16, rx);
        status_read_cmd(8'h08);
        $display("test refusals done");

        // Status write touches bits 3:2 only, then a timed busy cycle
        cmd(8'h06);
        host_u.frame(48'h01f4, 16, rx);
        status_read_cmd(8'hf7);
        cmd(8'h04);
        status_read_cmd(8'hf7);
        settle();
        status_read_cmd(8'h04);
        `CHK(status, 8'h04)
        `CHK(nv_out, 2'h1)
        $display("test status write done");

        // Two-entry buffer stalls: third byte dropped
        wr_ready = 1'b0;
        cmd(8'h06);
        host_u.frame(48'h02_10_112233, 40, rx);
        `CHK(overrun, 1'b1)
        wr_ready = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        `CHK(q.size(), 2)
        `CHK(q[0], {9'h010, 8'h11})
        `CHK(q[1], {9'h011, 8'h22})
        settle();
        q.delete();
        cmd(8'h06);
        `CHK(overrun, 1'b0)
        host_u.frame(48'h0a_80_00, 24, rx);
        settle();
        `CHK(q.size(), 0)
        cmd(8'h06);
        host_u.frame(48'h02_00_3cc3, 32, rx);
        settle();
        `CHK(q.size(), 2)
        $display("test array write done");

        // Read from the top address wraps to zero
        host_u.frame(48'h0b_ff_000000, 40, rx);
        `CHK(rx[23:0], 24'hff3cc3)
        host_u.frame(48'h03_10_0000, 32, rx);
        `CHK(rx[15:0], 16'h1122)
        $display("test array read done");
        end_sim();
    end
endmodule
`default_nettype wire
